// ==== brs_pkg.sv ====
// brs_pkg: constants, timing counts and state type for the bridge converter host.
// assumes a 100 MHz mclk; every count is derived from a time in its own unit.
`default_nettype none

package brs_pkg;

   // ==========================================================
   // clock and rounding
   localparam int CLK_PERIOD_NS = 10;

   // least time in ns to whole mclk cycles, never below one
   function automatic int brs_cyc_ceil(input int time_ns);
      int cyc;
      cyc = (time_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (cyc < 1) ? 1 : cyc;
   endfunction : brs_cyc_ceil

   // ==========================================================
   // pin timing
   localparam int SCLK_HALF_NS = 100;
   localparam int SCLK_HALF_CYC = brs_cyc_ceil(SCLK_HALF_NS);
   localparam int PD_MIN_NS = 26000;
   localparam int PD_MIN_CYC = brs_cyc_ceil(PD_MIN_NS);
   localparam int WAKE_NS = 7950;
   localparam int WAKE_CYC = brs_cyc_ceil(WAKE_NS);

   // standby activation time, equal to the conversion period of each rate
   localparam int STANDBY_FAST_US = 12500;
   localparam int STANDBY_SLOW_US = 100000;

   // ==========================================================
   // result framing
   localparam int RESULT_BITS = 24;
   localparam int FORCE_PULSE = 25;
   localparam logic [23:0] RESULT_POS_FULL = 24'h7fffff;
   localparam logic [23:0] RESULT_NEG_FULL = 24'h800000;
   localparam int TMR_W = 24;
   localparam int PH_W = 8;

   typedef enum logic [2:0] {
      ST_PD,
      ST_WAKE,
      ST_ARM,
      ST_IDLE,
      ST_SHIFT,
      ST_HOLD,
      ST_STANDBY
   } brs_state_type;

endpackage : brs_pkg

`default_nettype wire

// ==== brs_host.sv ====
// brs_host: host-side controller for a continuously converting 24-bit bridge converter.
// assumes the converter pins are wired directly; the serial output pin is asynchronous
// to mclk, the shift clock is made here by dividing mclk.
//
// Notes on behaviour
// - clock pulses shift 24 bits MSB first
// - finish the readout within one conversion period
// - never clock during the update blackout
// - 25th pulse forces pin high until ready
// - standby: hold clock high after ready low
// - standby may be requested mid readout
// - raise clock within standby request window
// - clock low wakes converter from standby
// - power-down pin low shuts converter down anytime
// - power-down at least 26 us, wake 7.95 us
// - power-down may interrupt a readout
`timescale 1ns/1ps
`default_nettype none

module brs_host
   import brs_pkg::*;
#(
   parameter int STANDBY_FAST_CYC = brs_cyc_ceil(STANDBY_FAST_US * 1000),
   parameter int STANDBY_SLOW_CYC = brs_cyc_ceil(STANDBY_SLOW_US * 1000)
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic read_enable,
   input wire logic force_high_en,
   input wire logic speed_high,
   input wire logic standby_req,
   input wire logic powerdown_req,
   input wire logic ready_and_serial_out,
   output logic sclk,
   output logic powerdown_n,
   output logic speed_sel,
   output logic [23:0] result,
   output logic result_valid,
   output logic result_clipped,
   output logic busy,
   output logic standby_active
);

   // ==========================================================
   // pin synchroniser
   logic data_meta;
   logic data_sync;

   always_ff @(posedge mclk) begin
      if (rst) begin
         data_meta <= 1'b1;
         data_sync <= 1'b1;
      end else begin
         data_meta <= ready_and_serial_out;
         data_sync <= data_meta;
      end
   end

   // ==========================================================
   // state, shift clock and timing
   brs_state_type state;
   logic [PH_W-1:0] ph;
   logic [4:0] bit_cnt;
   logic [TMR_W-1:0] tmr;
   logic [23:0] shreg;
   logic ph_end;
   logic [TMR_W-1:0] standby_cyc;
   logic [4:0] last_pulse;

   assign ph_end = (ph == PH_W'(SCLK_HALF_CYC - 1));
   assign standby_cyc = speed_sel ? TMR_W'(STANDBY_FAST_CYC) : TMR_W'(STANDBY_SLOW_CYC);
   // the extra pulse is only sent when the user wants the pin parked high
   assign last_pulse = force_high_en ? 5'(FORCE_PULSE) : 5'(RESULT_BITS);

   // rate pin follows the user choice one mclk cycle later, through a register
   always_ff @(posedge mclk) begin
      if (rst) begin
         speed_sel <= 1'b0;
      end else begin
         speed_sel <= speed_high;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         // reset starts with a full power-down cycle so the converter restarts clean
         state <= ST_PD;
         sclk <= 1'b0;
         powerdown_n <= 1'b0;
         ph <= '0;
         bit_cnt <= '0;
         tmr <= '0;
         shreg <= '0;
      end else if (powerdown_req && state != ST_PD) begin
         // power-down overrides everything, even mid readout
         state <= ST_PD;
         sclk <= 1'b0;
         powerdown_n <= 1'b0;
         tmr <= '0;
         ph <= '0;
         bit_cnt <= '0;
      end else begin
         case (state)
            ST_PD: begin
               powerdown_n <= 1'b0;
               sclk <= 1'b0;
               if (tmr < TMR_W'(PD_MIN_CYC - 1)) begin
                  tmr <= tmr + 1'b1;
               end else if (!powerdown_req) begin
                  powerdown_n <= 1'b1;
                  tmr <= '0;
                  state <= ST_WAKE;
               end
            end
            ST_WAKE: begin
               if (tmr == TMR_W'(WAKE_CYC - 1)) begin
                  tmr <= '0;
                  state <= ST_ARM;
               end else begin
                  tmr <= tmr + 1'b1;
               end
            end
            ST_ARM: begin
               // wait for high first: an unforced pin may still hold a low last bit
               if (data_sync) begin
                  state <= ST_IDLE;
               end
            end
            ST_IDLE: begin
               ph <= '0;
               bit_cnt <= '0;
               if (!data_sync) begin
                  if (standby_req) begin
                     // raised at once, well inside the request window
                     sclk <= 1'b1;
                     tmr <= '0;
                     state <= ST_HOLD;
                  end else if (read_enable) begin
                     // start on the low level itself, so the read ends far
                     // ahead of the next update and its blackout
                     sclk <= 1'b1;
                     state <= ST_SHIFT;
                  end
               end
            end
            ST_SHIFT: begin
               if (!ph_end) begin
                  ph <= ph + 1'b1;
               end else if (sclk) begin
                  ph <= '0;
                  sclk <= 1'b0;
               end else begin
                  ph <= '0;
                  bit_cnt <= bit_cnt + 1'b1;
                  // the pin moved to the next bit on the rising edge; sample late in low
                  if (bit_cnt < 5'(RESULT_BITS)) begin
                     shreg <= {shreg[22:0], data_sync};
                  end
                  if (standby_req) begin
                     sclk <= 1'b1;
                     tmr <= '0;
                     state <= ST_HOLD;
                  end else if (bit_cnt + 5'd1 == last_pulse) begin
                     state <= ST_ARM;
                  end else begin
                     sclk <= 1'b1;
                  end
               end
            end
            ST_HOLD: begin
               sclk <= 1'b1;
               if (tmr == standby_cyc - 1'b1) begin
                  state <= ST_STANDBY;
               end else begin
                  tmr <= tmr + 1'b1;
               end
            end
            ST_STANDBY: begin
               if (!standby_req) begin
                  // the first result after wakeup is valid but slow to come
                  sclk <= 1'b0;
                  state <= ST_ARM;
               end
            end
            default: begin
               state <= ST_PD;
               sclk <= 1'b0;
               powerdown_n <= 1'b0;
               tmr <= '0;
            end
         endcase
      end
   end

   // ==========================================================
   // result and status
   logic read_done;

   assign read_done = (state == ST_SHIFT) && ph_end && !sclk && !standby_req
      && !powerdown_req && (bit_cnt + 5'd1 >= 5'(RESULT_BITS))
      && (bit_cnt < 5'(RESULT_BITS));

   always_ff @(posedge mclk) begin
      if (rst) begin
         result <= '0;
         result_valid <= 1'b0;
         result_clipped <= 1'b0;
      end else begin
         result_valid <= read_done;
         if (read_done) begin
            result <= {shreg[22:0], data_sync};
            // full-scale codes mean the input was out of range
            result_clipped <= ({shreg[22:0], data_sync} == RESULT_POS_FULL)
               || ({shreg[22:0], data_sync} == RESULT_NEG_FULL);
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         busy <= 1'b1;
         standby_active <= 1'b0;
      end else begin
         busy <= (state == ST_PD) || (state == ST_WAKE) || (state == ST_SHIFT)
            || (state == ST_HOLD);
         standby_active <= (state == ST_STANDBY) && !powerdown_req;
      end
   end

   // ==========================================================
   // checks
   logic [TMR_W-1:0] pd_low_cnt;

   always_ff @(posedge mclk) begin
      if (rst) begin
         pd_low_cnt <= '0;
      end else if (powerdown_n) begin
         pd_low_cnt <= '0;
      end else begin
         pd_low_cnt <= pd_low_cnt + 1'b1;
      end
   end

   property p_pd_width;
      @(posedge mclk) disable iff (rst)
         $rose(powerdown_n) |-> pd_low_cnt >= TMR_W'(PD_MIN_CYC);
   endproperty
   a_pd_width: assert property (p_pd_width)
      else $error("power-down released too early");

   property p_no_clock_in_pd;
      @(posedge mclk) disable iff (rst)
         !powerdown_n |-> !sclk;
   endproperty
   a_no_clock_in_pd: assert property (p_no_clock_in_pd)
      else $error("shift clock high during power-down");

   // length of the current high level, saturating so a standby hold cannot wrap it
   logic [PH_W-1:0] hi_run;

   always_ff @(posedge mclk) begin
      if (rst) begin
         hi_run <= '0;
      end else if (!sclk) begin
         hi_run <= '0;
      end else if (hi_run != '1) begin
         hi_run <= hi_run + 1'b1;
      end
   end

   // only a power-down may cut a high phase short
   property p_high_width;
      @(posedge mclk) disable iff (rst)
         $fell(sclk) && !$past(powerdown_req) |-> hi_run >= PH_W'(SCLK_HALF_CYC);
   endproperty
   a_high_width: assert property (p_high_width)
      else $error("shift clock high phase too short");

   property p_start_on_ready;
      @(posedge mclk) disable iff (rst)
         $rose(sclk) && $past(state) == ST_IDLE |-> !$past(data_sync);
   endproperty
   a_start_on_ready: assert property (p_start_on_ready)
      else $error("readout started without ready low");

   property p_pulse_limit;
      @(posedge mclk) disable iff (rst)
         state == ST_SHIFT |-> bit_cnt < 5'(FORCE_PULSE);
   endproperty
   a_pulse_limit: assert property (p_pulse_limit)
      else $error("more than 25 shift pulses in one readout");

   property p_valid_after_bits;
      @(posedge mclk) disable iff (rst)
         result_valid |-> $past(bit_cnt, 2) == 5'(RESULT_BITS - 1) && !$past(sclk);
   endproperty
   a_valid_after_bits: assert property (p_valid_after_bits)
      else $error("result flagged before 24 bits");

   property p_standby_held;
      @(posedge mclk) disable iff (rst)
         $rose(standby_active) |-> sclk && $past(state, 2) == ST_HOLD;
   endproperty
   a_standby_held: assert property (p_standby_held)
      else $error("standby flagged without clock held high");

   property p_wake_low;
      @(posedge mclk) disable iff (rst)
         state == ST_STANDBY && !standby_req && !powerdown_req |=> !sclk ##1 !sclk;
   endproperty
   a_wake_low: assert property (p_wake_low)
      else $error("shift clock not dropped on wakeup");

   property p_hold_keeps_high;
      @(posedge mclk) disable iff (rst)
         state == ST_HOLD && !powerdown_req |=> sclk;
   endproperty
   a_hold_keeps_high: assert property (p_hold_keeps_high)
      else $error("shift clock dropped during standby hold");

   property p_pd_follows_req;
      @(posedge mclk) disable iff (rst)
         powerdown_req |=> !powerdown_n && !sclk;
   endproperty
   a_pd_follows_req: assert property (p_pd_follows_req)
      else $error("power-down request not obeyed on the next edge");

   property p_result_steady;
      @(posedge mclk) disable iff (rst)
         !result_valid |-> $stable(result);
   endproperty
   a_result_steady: assert property (p_result_steady)
      else $error("result changed without a valid pulse");

endmodule : brs_host

`default_nettype wire

// ==== brs_dev_model.sv ====
// brs_dev_model: behavioural bridge converter facing the host pins.
// assumes mclk stands in for its oscillator; next_result is set by the bench.
`timescale 1ns/1ps
`default_nettype none

module brs_dev_model #(
   parameter int CONV_FAST = 1200,
   parameter int CONV_SLOW = 2400,
   parameter int UPD_CYC = 90
) (
   input wire logic mclk,
   input wire logic sclk,
   input wire logic powerdown_n,
   input wire logic speed_sel,
   input wire logic [23:0] next_result,
   output logic ready_and_serial_out,
   output logic standby,
   output logic bridge_return_switch
);
   // ==========
   // conversion, shift and standby
   int conv;
   int cnt;
   int hi_cnt;
   int nbits;
   logic sclk_d;
   logic [23:0] shreg;

   always_comb conv = speed_sel ? CONV_FAST : CONV_SLOW;
   // bridge return closed only while converting
   always_comb bridge_return_switch = powerdown_n && !standby;

   // oscillator samples the shift clock, so glitches shorter than a cycle vanish
   always_ff @(posedge mclk) begin
      sclk_d <= sclk;
      if (!powerdown_n) begin
         cnt <= 0;
         hi_cnt <= 0;
         nbits <= 25;
         standby <= 1'b0;
         ready_and_serial_out <= 1'b1;
      end else if (standby) begin
         ready_and_serial_out <= 1'b1;
         if (!sclk) begin
            standby <= 1'b0;
            cnt <= 0;
         end
      end else begin
         hi_cnt <= sclk ? hi_cnt + 1 : 0;
         cnt <= (cnt >= conv - 1) ? 0 : cnt + 1;
         if (hi_cnt >= conv - 1) begin
            standby <= 1'b1;
            hi_cnt <= 0;
            ready_and_serial_out <= 1'b1;
         end else if (cnt >= conv - 1) begin
            shreg <= next_result;
            nbits <= 0;
            ready_and_serial_out <= 1'b0;
         end else if (cnt == conv - 1 - UPD_CYC) begin
            nbits <= 25;
            ready_and_serial_out <= 1'b1;
         end else if (sclk && !sclk_d && nbits < 25) begin
            nbits <= nbits + 1;
            shreg <= {shreg[22:0], 1'b0};
            ready_and_serial_out <= (nbits < 24) ? shreg[23] : 1'b1;
         end
      end
   end
endmodule : brs_dev_model

`default_nettype wire

// ==== brs_host_tb.sv ====
// brs_host_tb: self-checking bench for brs_host against the converter model.
// assumes small standby counts equal to the model's conversion periods.
`timescale 1ns/1ps
`default_nettype none

module brs_host_tb;
   import brs_pkg::*;
   // ==========
   // signals
   logic mclk, rst, read_enable, force_high_en, speed_high, standby_req, powerdown_req;
   logic sclk, powerdown_n, speed_sel, dout, result_valid, result_clipped, busy;
   logic standby_active, dev_standby, cur_f, seen, sw_closed;
   logic [23:0] result, next_result, cur, nv;
   int miscompares, num_checks, seed, pulses, lowc, k;

   brs_host #(.STANDBY_FAST_CYC(1200), .STANDBY_SLOW_CYC(2400)) uut (.mclk(mclk), .rst(rst),
      .read_enable(read_enable), .force_high_en(force_high_en), .speed_high(speed_high),
      .standby_req(standby_req), .powerdown_req(powerdown_req), .ready_and_serial_out(dout),
      .sclk(sclk), .powerdown_n(powerdown_n), .speed_sel(speed_sel), .result(result),
      .result_valid(result_valid), .result_clipped(result_clipped), .busy(busy),
      .standby_active(standby_active));
   brs_dev_model dev (.mclk(mclk), .sclk(sclk), .powerdown_n(powerdown_n),
      .speed_sel(speed_sel), .next_result(next_result), .ready_and_serial_out(dout),
      .standby(dev_standby), .bridge_return_switch(sw_closed));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge sclk) pulses++;
   // hang guard, far beyond the slowest expected run
   initial begin
      repeat (100000) @(posedge mclk);
      miscompares++;
      final_report();
   end

   // ==========
   // helpers
   function automatic logic exp_clip(input logic [23:0] v);
      return (v == RESULT_POS_FULL) || (v == RESULT_NEG_FULL);
   endfunction : exp_clip
   function automatic int exp_pulses(input logic f);
      return f ? FORCE_PULSE : RESULT_BITS;
   endfunction : exp_pulses
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t: seen %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick
   // expects cur, then queues the next value for the following conversion
   task automatic read_one(input logic [23:0] nxt, input logic nf);
      seen = 1'b0;
      for (int j = 0; j < 12000 && !seen; j++) begin
         tick(1);
         seen = (result_valid === 1'b1);
      end
      check(24'(seen), 24'h1);
      check(result, cur);
      check(24'(result_clipped), 24'(exp_clip(cur)));
      check(24'(speed_sel), 24'(speed_high));
      tick(40);
      check(24'(pulses), 24'(exp_pulses(cur_f)));
      check(24'(dout), 24'(cur_f ? 1'b1 : cur[0]));
      check(24'(busy), 24'h0);
      check(24'(sw_closed), 24'h1);
      @(posedge mclk);
      next_result <= nxt;
      force_high_en <= nf;
      speed_high <= 1'($random(seed));
      cur = nxt;
      cur_f = nf;
      pulses = 0;
      $display("read done at %0t", $time);
   endtask : read_one
   task automatic mid_shift();
      for (int j = 0; j < 5000 && pulses == 0; j++) tick(1);
      tick(30);
   endtask : mid_shift

   // ==========
   // sequence
   initial begin
      seed = 32'h50179b1a;
      rst = 1'b1;
      read_enable = 1'b0;
      force_high_en = 1'b0;
      speed_high = 1'b1;
      standby_req = 1'b0;
      powerdown_req = 1'b0;
      next_result = 24'h7fffff;
      cur = 24'h7fffff;
      cur_f = 1'b0;
      miscompares = 0;
      num_checks = 0;
      pulses = 0;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      read_enable <= 1'b1;
      for (lowc = 0; powerdown_n !== 1'b1 && lowc < 5000; lowc++) tick(1);
      check(24'(lowc >= PD_MIN_CYC), 24'h1);
      for (k = 0; k < 10; k++) begin
         nv = (k == 0) ? 24'h800000 : (k == 1) ? 24'h000000 : (k == 2) ? 24'hffffff
            : 24'($random(seed));
         read_one(nv, k[0]);
         if (k == 4) begin
            mid_shift();
            check(24'(busy), 24'h1);
            @(posedge mclk);
            powerdown_req <= 1'b1;
            @(posedge mclk);
            powerdown_req <= 1'b0;
            tick(0);
            check(24'({powerdown_n, sclk}), 24'h0);
            check(24'(sw_closed), 24'h0);
            seen = 1'b0;
            for (lowc = 1; powerdown_n !== 1'b1 && lowc < 5000; lowc++) begin
               tick(1);
               seen = seen | (result_valid === 1'b1);
            end
            check(24'({seen, lowc >= PD_MIN_CYC}), 24'h1);
            pulses = 0;
         end
         if (k == 7) begin
            mid_shift();
            @(posedge mclk);
            standby_req <= 1'b1;
            for (lowc = 0; standby_active !== 1'b1 && lowc < 6000; lowc++) tick(1);
            tick(5);
            check(24'({dev_standby, dout, sclk}), 24'h7);
            check(24'(sw_closed), 24'h0);
            @(posedge mclk);
            standby_req <= 1'b0;
            tick(4);
            check(24'({dev_standby, sclk, standby_active}), 24'h0);
            pulses = 0;
         end
      end
      read_one(24'h000001, 1'b0);
      final_report();
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : final_report
endmodule : brs_host_tb

`default_nettype wire
